// ### design/opsh_top.sv
// One-shot pulse generator: delay channel, width channel, APB registers
// Behaviour
// [RULE1] Both start bits written together start pulse
// [RULE2] Delay channel fires immediately, no delay; the code waits for the next tick, up to 7 cycles after the trigger
// [RULE3] Delay channel stops until next trigger
// [RULE4] Delay done starts width channel, pin high
// [RULE5] Width elapsed: interrupt, pin low till next
// [RULE6] Software loads width count register
// [RULE7] Channels count at 32 MHz tick
// [RULE8] Software unmasks delay interrupt, then triggers; the block has no interrupt mask, the delay irq always reaches its output
// [RULE9] Drive enable selects timer wave, else software
// [RULE10] Trigger bit one sets enabled flag
// [RULE11] Pin rests low before first trigger
`timescale 1ns/1ps
`default_nettype none

module opsh_top
  import opsh_pkg::*;
#(
  parameter int WIDTH_BITS = 16
)
(
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_reset_n,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output var  logic [31:0] o_prdata,
  output var  logic        o_pready,
  output var  logic        o_pslverr,
  // Pulse pin and events
  output var  logic        o_pulse_output_pin,
  output var  logic        o_delay_channel_done_irq,
  output var  logic        o_width_channel_done_irq
);

  logic [7:0]            acc_reg;
  logic                  tick;
  logic                  delay_en_reg;
  opsh_wstate_t          wstate_reg;
  logic [WIDTH_BITS-1:0] count_reg;
  logic [WIDTH_BITS-1:0] width_count_value_reg;
  logic                  wave_reg;
  logic                  drive_en_reg;
  logic                  sw_level_reg;
  logic                  wr_en;
  logic                  setup;
  logic                  delay_fire;
  logic                  width_end;
  opsh_status_t          status;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  assign setup = i_psel && !i_penable;
  assign wr_en = i_psel && i_penable && o_pready && i_pwrite;

  // Fractional divider: 32 MHz enable from 200 MHz, no integer ratio
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      acc_reg <= 8'h00;
      tick    <= 1'b0;
    end
    else if (acc_reg + OPSH_ACC_STEP >= OPSH_ACC_WRAP)
    begin
      acc_reg <= acc_reg + OPSH_ACC_STEP - OPSH_ACC_WRAP; // [RULE7]
      tick    <= 1'b1;
    end
    else
    begin
      acc_reg <= acc_reg + OPSH_ACC_STEP;
      tick    <= 1'b0;
    end
  end

  assign delay_fire = delay_en_reg && tick;
  assign width_end  = (wstate_reg == OPSH_W_RUN) && tick &&
                      (count_reg <= WIDTH_BITS'(1));

  // Delay channel: one-count, fires on the next tick
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
      delay_en_reg <= 1'b0;
    else if (wr_en && hit(i_paddr, OPSH_TRIG_OFS) && i_pwdata[OPSH_DLY_TRIG_BIT])
      delay_en_reg <= 1'b1; // [RULE10] [RULE1]
    else if (delay_fire)
      delay_en_reg <= 1'b0; // [RULE3]
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
      o_delay_channel_done_irq <= 1'b0;
    else
      o_delay_channel_done_irq <= delay_fire; // [RULE2]
  end

  // Width channel
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      wstate_reg <= OPSH_W_IDLE;
      count_reg  <= '0;
      wave_reg   <= 1'b0; // [RULE11]
    end
    else
    begin
      unique case (wstate_reg)
        OPSH_W_IDLE:
        begin
          if (wr_en && hit(i_paddr, OPSH_TRIG_OFS) && i_pwdata[OPSH_WID_TRIG_BIT])
            wstate_reg <= OPSH_W_ARMED; // [RULE10] [RULE1]
        end
        OPSH_W_ARMED:
        begin
          if (delay_fire)
          begin
            wstate_reg <= OPSH_W_RUN; // [RULE4]
            count_reg  <= width_count_value_reg;
            wave_reg   <= 1'b1;
          end
        end
        OPSH_W_RUN:
        begin
          if (width_end)
          begin
            wstate_reg <= OPSH_W_ARMED; // [RULE5]
            wave_reg   <= 1'b0;
          end
          else if (tick)
            count_reg <= count_reg - WIDTH_BITS'(1);
        end
        default:
        begin
          wstate_reg <= OPSH_W_IDLE;
          wave_reg   <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
      o_width_channel_done_irq <= 1'b0;
    else
      o_width_channel_done_irq <= width_end; // [RULE5]
  end

  // Output control register
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      drive_en_reg <= OPSH_DRIVE_EN_RST;
      sw_level_reg <= OPSH_SW_LEVEL_RST;
    end
    else if (wr_en && hit(i_paddr, OPSH_OUTCTL_OFS))
    begin
      drive_en_reg <= i_pwdata[OPSH_DRIVE_EN_BIT];
      // Level write is ignored while the timer owns the pin
      if (!drive_en_reg)
        sw_level_reg <= i_pwdata[OPSH_SW_LEVEL_BIT]; // [RULE9]
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
      width_count_value_reg <= WIDTH_BITS'(OPSH_WIDTH_RST);
    else if (wr_en && hit(i_paddr, OPSH_WIDTH_OFS))
      width_count_value_reg <= i_pwdata[WIDTH_BITS-1:0]; // [RULE6]
  end

  // Pin lags the wave by one cycle so it leaves a flop
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
      o_pulse_output_pin <= 1'b0; // [RULE11]
    else
      o_pulse_output_pin <= drive_en_reg ? wave_reg : sw_level_reg; // [RULE9]
  end

  // APB answer: one wait-free access phase after setup
  always_comb
  begin
    status          = '0;
    status.count    = 16'(count_reg);
    status.pin      = o_pulse_output_pin;
    status.running  = (wstate_reg == OPSH_W_RUN);
    status.width_en = (wstate_reg != OPSH_W_IDLE);
    status.delay_en = delay_en_reg;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end
    else
    begin
      o_pready  <= setup;
      o_pslverr <= setup && !(hit(i_paddr, OPSH_TRIG_OFS) ||
                   hit(i_paddr, OPSH_OUTCTL_OFS) ||
                   hit(i_paddr, OPSH_WIDTH_OFS) ||
                   hit(i_paddr, OPSH_STATUS_OFS));
      o_prdata  <= 32'h0000_0000;
      if (setup && !i_pwrite)
      begin
        if (hit(i_paddr, OPSH_OUTCTL_OFS))
          o_prdata <= {30'h0, sw_level_reg, drive_en_reg};
        else if (hit(i_paddr, OPSH_WIDTH_OFS))
          o_prdata <= 32'(width_count_value_reg);
        else if (hit(i_paddr, OPSH_STATUS_OFS))
          o_prdata <= status;
      end
    end
  end

  // Checks
  property p_both_start;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (wr_en && hit(i_paddr, OPSH_TRIG_OFS) && i_pwdata[1:0] == 2'b11 &&
     wstate_reg == OPSH_W_IDLE)
    |=> delay_en_reg && wstate_reg == OPSH_W_ARMED;
  endproperty
  a_both_start: assert property (p_both_start) else $error("start failed"); // [RULE1]

  property p_zero_delay;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    $rose(delay_en_reg) |-> ##[1:8] o_delay_channel_done_irq;
  endproperty
  a_zero_delay: assert property (p_zero_delay) else $error("delay late"); // [RULE2]

  property p_delay_stops;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    o_delay_channel_done_irq && !$past(wr_en) |-> !delay_en_reg;
  endproperty
  a_delay_stops: assert property (p_delay_stops) else $error("delay runs"); // [RULE3]

  property p_width_start;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (delay_fire && wstate_reg == OPSH_W_ARMED)
    |=> wave_reg && wstate_reg == OPSH_W_RUN
        && count_reg == $past(width_count_value_reg);
  endproperty
  a_width_start: assert property (p_width_start) else $error("no start"); // [RULE4]

  property p_width_end;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    o_width_channel_done_irq |-> !wave_reg && wstate_reg == OPSH_W_ARMED
                                 && $past(count_reg) <= WIDTH_BITS'(1);
  endproperty
  a_width_end: assert property (p_width_end) else $error("bad end"); // [RULE5]

  property p_tick_rate;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    tick |=> !tick [*5];
  endproperty
  a_tick_rate: assert property (p_tick_rate) else $error("tick fast"); // [RULE7]

  property p_pin_source;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    $past(drive_en_reg) |-> o_pulse_output_pin == $past(wave_reg);
  endproperty
  a_pin_source: assert property (p_pin_source) else $error("pin wrong"); // [RULE9]

  property p_sw_ignored;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    drive_en_reg |=> sw_level_reg == $past(sw_level_reg);
  endproperty
  a_sw_ignored: assert property (p_sw_ignored) else $error("sw write"); // [RULE9]

  property p_trig_flag;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (wr_en && hit(i_paddr, OPSH_TRIG_OFS) && i_pwdata[OPSH_WID_TRIG_BIT])
    |=> wstate_reg != OPSH_W_IDLE;
  endproperty
  a_trig_flag: assert property (p_trig_flag) else $error("flag lost"); // [RULE10]

  property p_rest_low;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    wstate_reg != OPSH_W_RUN |-> !wave_reg;
  endproperty
  a_rest_low: assert property (p_rest_low) else $error("pin high"); // [RULE11]

endmodule

`default_nettype wire

// ### dv/opsh_top_tb_top.sv
// Self-checking bench of the one-shot pulse block
`timescale 1ns/1ps
`default_nettype none

module opsh_top_tb_top;
  import opsh_pkg::*;

  logic        clk     = 1'b0;
  logic        rst_n   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin;
  logic        dirq;
  logic        wirq;
  logic [31:0] rd;
  logic        er;
  int          fail_count = 0;
  int          checks     = 0;
  int          cyc        = 0;
  int          w;
  int          m;

  always #2.5 clk = ~clk;

  opsh_top dut_u (
    .i_core_clk               (clk),
    .i_reset_n                (rst_n),
    .i_psel                   (psel),
    .i_penable                (penable),
    .i_pwrite                 (pwrite),
    .i_paddr                  (paddr),
    .i_pwdata                 (pwdata),
    .o_prdata                 (prdata),
    .o_pready                 (pready),
    .o_pslverr                (pslverr),
    .o_pulse_output_pin       (pin),
    .o_delay_channel_done_irq (dirq),
    .o_width_channel_done_irq (wirq)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_win(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // No wait limit here: only the bench timeout may end a stalled access
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Idle cycle keeps each strobe to one assignment per step
    @(posedge clk);
  endtask

  // Trigger, then follow irq and pin through one pulse of wd ticks
  task automatic pulse(input logic [1:0] trig, input int wd);
    int n;
    int k;
    apb(1'b1, OPSH_TRIG_OFS, {30'h0, trig});
    n = 0;
    while (dirq !== 1'b1 && n < 12)
    begin
      @(posedge clk);
      n++;
    end
    chk_win(n, 1, 10);
    @(posedge clk);
    chk(pin, 1'b1);
    n = 0;
    k = 0;
    while (wirq !== 1'b1 && n < 45000)
    begin
      @(posedge clk);
      n++;
      k += (dirq === 1'b1);
    end
    chk(k, 0);
    chk(pin, 1'b1);
    // Tick spacing is 6 or 7 cycles, so allow a few cycles of slack
    chk_win(n * 4, wd * 25 - 32, wd * 25 + 32);
    @(posedge clk);
    chk(pin, 1'b0);
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, cyc, 0);
      end_of_test();
    end
  end

  initial
  begin
    void'($urandom(63));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({pin, dirq, wirq}, 3'b000);
    apb(1'b0, OPSH_OUTCTL_OFS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, OPSH_WIDTH_OFS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, OPSH_STATUS_OFS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, OPSH_TRIG_OFS, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, 8'h14, $urandom);
    chk({31'h0, er}, 32'h1);
    $display("test reset and map done");
    apb(1'b1, OPSH_OUTCTL_OFS, 32'h2);
    @(posedge clk);
    chk(pin, 1'b1);
    apb(1'b1, OPSH_OUTCTL_OFS, 32'h0);
    @(posedge clk);
    chk(pin, 1'b0);
    apb(1'b1, OPSH_OUTCTL_OFS, 32'h1);
    apb(1'b1, OPSH_OUTCTL_OFS, 32'h3);
    apb(1'b0, OPSH_OUTCTL_OFS, 32'h0);
    chk(rd, 32'h1);
    chk(pin, 1'b0);
    $display("test output select done");
    apb(1'b1, OPSH_TRIG_OFS, 32'h0);
    m = 0;
    repeat (12)
    begin
      @(posedge clk);
      m += (dirq === 1'b1);
    end
    chk(m, 0);
    apb(1'b0, OPSH_STATUS_OFS, 32'h0);
    chk(rd & 32'hf, 32'h0);
    $display("test zero trigger done");
    for (int i = 0; i < 4; i++)
    begin
      w = (i < 2) ? i : int'($urandom_range(300, 2));
      apb(1'b1, OPSH_WIDTH_OFS, w);
      apb(1'b0, OPSH_WIDTH_OFS, 32'h0);
      chk(rd, w);
      pulse((i == 0) ? 2'b11 : 2'b01, (w < 1) ? 1 : w);
      apb(1'b0, OPSH_STATUS_OFS, 32'h0);
      chk(rd & 32'hf, 32'h2);
    end
    $display("test short pulses done");
    apb(1'b1, OPSH_WIDTH_OFS, 32'h1900);
    pulse(2'b11, 6400);
    $display("test long pulse done");
    end_of_test();
  end
endmodule

`default_nettype wire

// ### pkg/opsh_pkg.sv
// Shared constants and types of the one-shot pulse block
package opsh_pkg;

  // Register byte offsets
  localparam logic [7:0] OPSH_TRIG_OFS   = 8'h00;
  localparam logic [7:0] OPSH_OUTCTL_OFS = 8'h04;
  localparam logic [7:0] OPSH_WIDTH_OFS  = 8'h08;
  localparam logic [7:0] OPSH_STATUS_OFS = 8'h0c;

  // Field positions
  localparam int OPSH_DLY_TRIG_BIT = 0;
  localparam int OPSH_WID_TRIG_BIT = 1;
  localparam int OPSH_DRIVE_EN_BIT = 0;
  localparam int OPSH_SW_LEVEL_BIT = 1;

  // Reset values
  localparam logic        OPSH_DRIVE_EN_RST = 1'b0;
  localparam logic        OPSH_SW_LEVEL_RST = 1'b0;
  localparam logic [15:0] OPSH_WIDTH_RST    = 16'h0000;

  // Timing: core clock and counter clock, in kHz
  localparam int OPSH_CORE_KHZ = 200000;
  localparam int OPSH_TICK_KHZ = 32000;
  localparam logic [7:0] OPSH_ACC_STEP = 8'(OPSH_TICK_KHZ / 1000);
  localparam logic [7:0] OPSH_ACC_WRAP = 8'(OPSH_CORE_KHZ / 1000);

  // Width channel states
  typedef enum logic [2:0] {
    OPSH_W_IDLE  = 3'b001,
    OPSH_W_ARMED = 3'b010,
    OPSH_W_RUN   = 3'b100
  } opsh_wstate_t;

  // Status word layout
  typedef struct packed {
    logic [15:0] count;
    logic [11:0] zero;
    logic        pin;
    logic        running;
    logic        width_en;
    logic        delay_en;
  } opsh_status_t;

endpackage
